// ==== verilog/lqld_pkg.sv ====
// Purpose: shared constants and types for the link quality and line driver register slice
// Assumes: 16-bit register words reached over a plain strobe port
// Notes:   offsets are the printed register addresses; reserved bits are not stored

package lqld_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // register port geometry
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 16;

  // register offsets
  localparam logic [15:0] OFS_QUAL = 16'h0198;
  localparam logic [15:0] OFS_TERM = 16'h0400;
  localparam logic [15:0] OFS_GAIN = 16'h0401;

  //////////////////////////////////////////////////////////////////////////////
  // quality register layout
  localparam int unsigned QCLASS_LSB = 8;
  localparam int unsigned QCLASS_MSB = 9;
  localparam int unsigned QVAL_LSB   = 0;
  localparam int unsigned QVAL_MSB   = 7;
  localparam logic [7:0]  QVAL_RST   = 8'h00;

  // class thresholds: above 70 excellent, 40 up to 70 good, below 40 poor
  localparam logic [7:0]  QVAL_EXCELLENT_ABOVE = 8'h46;
  localparam logic [7:0]  QVAL_GOOD_MIN        = 8'h28;

  //////////////////////////////////////////////////////////////////////////////
  // termination register layout
  localparam int unsigned TERM_LSB = 8;
  localparam int unsigned TERM_MSB = 12;
  localparam logic [4:0]  TERM_RST = 5'h10;  // the 45.6 ohm setting

  // fine gain register layout
  localparam int unsigned GAIN_LSB     = 0;
  localparam int unsigned GAIN_MSB     = 3;
  localparam logic [3:0]  GAIN_RST     = 4'ha;  // plus four percent
  localparam logic [3:0]  GAIN_NEUTRAL = 4'h8;  // swing unchanged
  localparam int unsigned GAIN_STEP_SHIFT = 1;  // two percent per code

  // reserved bits read back as their defaults
  localparam logic [15:0] RSVD_RD_VALUE = 16'h0000;

  //////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {
    LQLD_NO_LINK,
    LQLD_POOR,
    LQLD_GOOD,
    LQLD_EXCELLENT
  } lqld_class_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } lqld_bus_req_t;

  typedef struct packed {
    logic       sample;
    logic       link_up;
    logic [7:0] value;
  } lqld_quality_t;

  // class for a quality value taken with the link up
  function automatic lqld_class_t lqld_classify(input logic [7:0] value);
    if (value > QVAL_EXCELLENT_ABOVE) begin
      return LQLD_EXCELLENT;
    end else if (value >= QVAL_GOOD_MIN) begin
      return LQLD_GOOD;
    end else begin
      return LQLD_POOR;
    end
  endfunction : lqld_classify

endpackage : lqld_pkg

// ==== verilog/lqld_quality_class.sv ====
// Purpose: holds the quality value and its class, updated from the link monitor
// Assumes: monitor inputs are synchronous to ref_clk_i
// Notes:   value and class are taken in the same edge so they never disagree

`timescale 1ns/1ps
`default_nettype none

module lqld_quality_class
  import lqld_pkg::*;
(
  input  wire logic          ref_clk_i,  // device clock
  input  wire logic          sys_rst_i,  // async reset, active high
  input  wire lqld_quality_t quality_i,  // monitor sample
  output lqld_class_t        class_o,    // held quality class
  output logic [7:0]         value_o     // held quality value
);

  //////////////////////////////////////////////////////////////////////////////
  // capture on each sample; a dropped link forces value to zero so that a
  // stale figure cannot sit beside the no-link class
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      class_o <= LQLD_NO_LINK;
      value_o <= QVAL_RST;
    end else if (quality_i.sample) begin
      if (!quality_i.link_up) begin
        class_o <= LQLD_NO_LINK;
        value_o <= QVAL_RST;
      end else begin
        class_o <= lqld_classify(quality_i.value);
        value_o <= quality_i.value;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  property p_class_tracks_value;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    quality_i.sample && quality_i.link_up |=>
      class_o == lqld_classify(value_o) && class_o != LQLD_NO_LINK;
  endproperty
  a_class_tracks_value : assert property (p_class_tracks_value)
    else $error("quality class does not match quality value");

  property p_no_link_clears;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    quality_i.sample && !quality_i.link_up |=> class_o == LQLD_NO_LINK && value_o == QVAL_RST;
  endproperty
  a_no_link_clears : assert property (p_no_link_clears)
    else $error("no-link sample did not clear class and value");

endmodule : lqld_quality_class

`default_nettype wire

// ==== verilog/lqld_regs.sv ====
// Purpose: register slice for link quality report and line driver settings
// Assumes: one clock, strobes one cycle long, read data one cycle after strobe
// Notes:   reserved bits are not stored and read as their defaults
//
// Contract
// - two-bit quality class in bits 9:8, reset zero, read only
// - eight-bit quality value in bits 7:0, consistent with the class
// - value above 70 excellent, 40 to 70 good, below 40 poor or none
// - five-bit termination code in bits 12:8, read/write, reset 1 0000
// - default termination code selects the 45.6 ohm setting
// - four-bit fine gain in bits 3:0, read/write, code 1000 neutral
// - fine gain steps two percent, 0000 is minus sixteen percent
// - fine gain resets to 1010, plus four percent
//
// The plain strobed port was chosen for this implementation.

`timescale 1ns/1ps
`default_nettype none

module lqld_regs
  import lqld_pkg::*;
(
  input  wire logic              ref_clk_i,        // device clock, 100 MHz
  input  wire logic              sys_rst_i,        // async reset, active high
  input  wire lqld_bus_req_t     bus_req_i,        // register request
  input  wire lqld_quality_t     quality_i,        // link monitor sample
  output logic [DATA_W-1:0]      rdata_o,          // read data, cycle after strobe
  output logic [4:0]             term_sel_o,       // series termination code
  output logic [3:0]             fine_gain_o,      // fine swing code
  output logic signed [5:0]      fine_gain_pct_o,  // swing change in percent
  output lqld_class_t            quality_class_o   // quality class for status pins
);

  //////////////////////////////////////////////////////////////////////////////
  // address decode, used by the write and read paths alike
  function automatic logic addr_hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] ofs);
    return addr == ofs;
  endfunction : addr_hit

  // swing change of a fine gain code; neutral code gives zero
  function automatic logic signed [5:0] gain_pct(input logic [3:0] code);
    logic signed [5:0] delta;
    delta = $signed({2'b00, code}) - $signed({2'b00, GAIN_NEUTRAL});
    return delta <<< GAIN_STEP_SHIFT;
  endfunction : gain_pct

  // reset value of the percent figure, fixed so the reset branch holds only constants
  localparam logic signed [5:0] GAIN_RST_PCT = gain_pct(GAIN_RST);

  //////////////////////////////////////////////////////////////////////////////
  // internal state
  lqld_class_t       qual_class;
  logic [7:0]        qual_value;
  logic [4:0]        term_sel_reg;
  logic [4:0]        term_sel_next;
  logic [3:0]        fine_gain_reg;
  logic [3:0]        fine_gain_next;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic              wr_term;
  logic              wr_gain;
  logic              term_written_reg;
  logic              gain_written_reg;

  //////////////////////////////////////////////////////////////////////////////
  // quality holder; it has no write path at all, so software cannot disturb it
  lqld_quality_class u_quality (
    .ref_clk_i (ref_clk_i),
    .sys_rst_i (sys_rst_i),
    .quality_i (quality_i),
    .class_o   (qual_class),
    .value_o   (qual_value)
  );

  //////////////////////////////////////////////////////////////////////////////
  // write decode; a write to the quality offset matches nothing here
  assign wr_term = bus_req_i.wr && addr_hit(bus_req_i.addr, OFS_TERM);
  assign wr_gain = bus_req_i.wr && addr_hit(bus_req_i.addr, OFS_GAIN);

  // next values of the two control fields; reserved bits of wdata are dropped
  always_comb begin
    term_sel_next  = term_sel_reg;
    fine_gain_next = fine_gain_reg;
    if (wr_term) begin
      term_sel_next = bus_req_i.wdata[TERM_MSB:TERM_LSB];
    end
    if (wr_gain) begin
      fine_gain_next = bus_req_i.wdata[GAIN_MSB:GAIN_LSB];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // termination code; the reset code is the 45.6 ohm step
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      term_sel_reg <= TERM_RST;
    end else begin
      term_sel_reg <= term_sel_next;
    end
  end

  // fine gain code; reset leaves the swing four percent above neutral
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fine_gain_reg <= GAIN_RST;
    end else begin
      fine_gain_reg <= fine_gain_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // driver outputs come straight from flops; the percent figure is registered
  // from the next code so that it moves in the same edge as the code itself
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      term_sel_o      <= TERM_RST;
      fine_gain_o     <= GAIN_RST;
      fine_gain_pct_o <= GAIN_RST_PCT;
    end else begin
      term_sel_o      <= term_sel_next;
      fine_gain_o     <= fine_gain_next;
      fine_gain_pct_o <= gain_pct(fine_gain_next);
    end
  end

  // class copy for status pins; one cycle behind the held class
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      quality_class_o <= LQLD_NO_LINK;
    end else begin
      quality_class_o <= qual_class;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read mux; reserved bits carry their default, unmapped offsets read zero,
  // and with no read strobe the data bus returns to zero
  always_comb begin
    rdata_next = RSVD_RD_VALUE;
    if (bus_req_i.rd) begin
      if (addr_hit(bus_req_i.addr, OFS_QUAL)) begin
        rdata_next[QCLASS_MSB:QCLASS_LSB] = qual_class;
        rdata_next[QVAL_MSB:QVAL_LSB]     = qual_value;
      end else if (addr_hit(bus_req_i.addr, OFS_TERM)) begin
        rdata_next[TERM_MSB:TERM_LSB] = term_sel_reg;
      end else if (addr_hit(bus_req_i.addr, OFS_GAIN)) begin
        rdata_next[GAIN_MSB:GAIN_LSB] = fine_gain_reg;
      end else begin
        rdata_next = RSVD_RD_VALUE;
      end
    end
  end

  // read data register; valid only in the cycle after the strobe
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_reg <= RSVD_RD_VALUE;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign rdata_o = rdata_reg;

  //////////////////////////////////////////////////////////////////////////////
  // helper flags for the checks below: set by the first write after reset
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      term_written_reg <= 1'b0;
    end else if (wr_term) begin
      term_written_reg <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      gain_written_reg <= 1'b0;
    end else if (wr_gain) begin
      gain_written_reg <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // quality read returns the class and value held at the strobe
  property p_qual_read;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    bus_req_i.rd && bus_req_i.addr == OFS_QUAL |=>
      rdata_o[QCLASS_MSB:QCLASS_LSB] == $past(qual_class) &&
      rdata_o[QVAL_MSB:QVAL_LSB] == $past(qual_value) &&
      rdata_o[15:10] == 6'h00;
  endproperty
  a_qual_read : assert property (p_qual_read)
    else $error("quality read returned wrong class or value");

  // the value read back sits in the band of the class read with it whenever that class is not none
  property p_qual_consistent;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    $past(bus_req_i.rd) && $past(bus_req_i.addr) == OFS_QUAL && rdata_o[9:8] != 2'h0 |->
      rdata_o[9:8] == lqld_classify(rdata_o[7:0]);
  endproperty
  a_qual_consistent : assert property (p_qual_consistent)
    else $error("quality value and class disagree on read");

  // an excellent class never stands beside a value of 70 or less
  property p_excellent_band;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    qual_class == LQLD_EXCELLENT |-> qual_value > QVAL_EXCELLENT_ABOVE;
  endproperty
  a_excellent_band : assert property (p_excellent_band)
    else $error("excellent class with value not above 70");

  // a termination write lands on the pins in the next cycle
  property p_term_write;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    bus_req_i.wr && bus_req_i.addr == OFS_TERM |=>
      term_sel_o == $past(bus_req_i.wdata[TERM_MSB:TERM_LSB]);
  endproperty
  a_term_write : assert property (p_term_write)
    else $error("termination write not applied");

  // a termination read returns the code standing on the pins at the strobe
  property p_term_readback;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    bus_req_i.rd && bus_req_i.addr == OFS_TERM |=>
      rdata_o[TERM_MSB:TERM_LSB] == $past(term_sel_o);
  endproperty
  a_term_readback : assert property (p_term_readback)
    else $error("termination read does not match the pins");

  // until the first write, the termination code stays at its default
  property p_term_default;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    !term_written_reg |-> term_sel_o == 5'h10;
  endproperty
  a_term_default : assert property (p_term_default)
    else $error("termination code left default without a write");

  // a fine gain write reaches the pins in the next cycle
  property p_gain_write;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    bus_req_i.wr && bus_req_i.addr == OFS_GAIN |=> fine_gain_o == $past(bus_req_i.wdata[3:0]);
  endproperty
  a_gain_write : assert property (p_gain_write)
    else $error("fine gain write not applied");

  // a fine gain read returns the code standing on the pins at the strobe
  property p_gain_readback;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    bus_req_i.rd && bus_req_i.addr == OFS_GAIN |=>
      rdata_o[GAIN_MSB:GAIN_LSB] == $past(fine_gain_o);
  endproperty
  a_gain_readback : assert property (p_gain_readback)
    else $error("fine gain read does not match the pins");

  // percent figure follows the code at two percent per step
  property p_gain_pct;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (fine_gain_o != 4'h0 || fine_gain_pct_o == -6'sd16) &&
      (fine_gain_o != 4'h8 || fine_gain_pct_o == 6'sd0) &&
      (fine_gain_pct_o == 2 * ($signed({2'b00, fine_gain_o}) - 6'sd8));
  endproperty
  a_gain_pct : assert property (p_gain_pct)
    else $error("fine gain percent does not match code");

  // until the first write, the fine gain stays at plus four percent
  property p_gain_default;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    !gain_written_reg |-> fine_gain_o == 4'ha && fine_gain_pct_o == 6'sd4;
  endproperty
  a_gain_default : assert property (p_gain_default)
    else $error("fine gain left default without a write");

  // control registers read with reserved bits at zero
  property p_rsvd_read;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    bus_req_i.rd && (bus_req_i.addr == OFS_TERM || bus_req_i.addr == OFS_GAIN) |=>
      rdata_o[15:13] == 3'h0 && rdata_o[7:4] == 4'h0 &&
      (rdata_o[12:8] == 5'h00 || $past(bus_req_i.addr) == OFS_TERM) &&
      (rdata_o[3:0] == 4'h0 || $past(bus_req_i.addr) == OFS_GAIN);
  endproperty
  a_rsvd_read : assert property (p_rsvd_read)
    else $error("reserved bits not read as zero");

  // a write to the quality offset changes neither control field
  property p_qual_write_ignored;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    bus_req_i.wr && bus_req_i.addr == OFS_QUAL |=> $stable(term_sel_o) && $stable(fine_gain_o);
  endproperty
  a_qual_write_ignored : assert property (p_qual_write_ignored)
    else $error("write to quality register changed a control field");

  // unmapped reads and idle cycles return zero
  property p_idle_zero;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    !bus_req_i.rd || (bus_req_i.addr != OFS_QUAL && bus_req_i.addr != OFS_TERM &&
      bus_req_i.addr != OFS_GAIN) |=> rdata_o == 16'h0000;
  endproperty
  a_idle_zero : assert property (p_idle_zero)
    else $error("read data not zero outside a mapped read");

  // status pin copy trails the held class by exactly one cycle
  property p_class_pin;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    quality_class_o == $past(qual_class);
  endproperty
  a_class_pin : assert property (p_class_pin)
    else $error("class status pin does not trail the held class");

endmodule : lqld_regs

`default_nettype wire

// ==== verification/lqld_regs_tb.sv ====
// Purpose: self-checking bench for the link quality and line driver register slice
// Assumes: plain strobe register port, read data in the cycle after the strobe
// Notes:   an integer model in the bench predicts every register word and status output

`timescale 1ns/1ps
`default_nettype none

module lqld_regs_tb
  import lqld_pkg::*;
;

  //////////////////////////////////////////////////////////////////////////////
  // stimulus and observation signals
  logic                 ref_clk_i;
  logic                 sys_rst_i;
  lqld_bus_req_t        bus_req_i;
  lqld_quality_t        quality_i;
  logic [DATA_W-1:0]    rdata_o;
  logic [4:0]           term_sel_o;
  logic [3:0]           fine_gain_o;
  logic signed [5:0]    fine_gain_pct_o;
  lqld_class_t          quality_class_o;
  integer               seed;
  int                   n_fail;
  int                   checked;
  int                   i;
  int                   v;
  int                   lk;
  int                   qv[$];
  logic [15:0]          d;
  logic [15:0]          q;

  lqld_regs lqld_regs_inst (
    .ref_clk_i       (ref_clk_i),
    .sys_rst_i       (sys_rst_i),
    .bus_req_i       (bus_req_i),
    .quality_i       (quality_i),
    .rdata_o         (rdata_o),
    .term_sel_o      (term_sel_o),
    .fine_gain_o     (fine_gain_o),
    .fine_gain_pct_o (fine_gain_pct_o),
    .quality_class_o (quality_class_o)
  );

  // free running 100 MHz clock
  always #5 ref_clk_i = ~ref_clk_i;

  //////////////////////////////////////////////////////////////////////////////
  // one comparison, counted, reported only on a mismatch
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // verdict and end of run, shared with the watchdog
  task automatic test_done();
    if (n_fail == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done

  // one strobe cycle; back to back calls give gapless strobes
  task automatic bus_cycle(input logic wr, input logic [15:0] a, input logic [15:0] wd);
    @(posedge ref_clk_i);
    bus_req_i <= '{addr: a, wdata: wd, wr: wr, rd: !wr};
  endtask : bus_cycle

  // release the port at the edge that takes the last strobe, then sample the answer
  task automatic bus_idle_read(output logic [15:0] rd_q);
    @(posedge ref_clk_i);
    bus_req_i <= '0;
    #1 rd_q = rdata_o;
  endtask : bus_idle_read

  // plain read of one register word
  task automatic bus_rd(input logic [15:0] a, output logic [15:0] rd_q);
    bus_cycle(1'b0, a, 16'h0000);
    bus_idle_read(rd_q);
  endtask : bus_rd

  // model of the class field: link down reads none, otherwise by thresholds
  function automatic int exp_class(input int link, input int val);
    if (link == 0) return 0;
    if (val > 70) return 3;
    if (val >= 40) return 2;
    return 1;
  endfunction : exp_class

  // reset for 12 cycles, then every default at pins and through the port
  task automatic reset_chk();
    @(posedge ref_clk_i);
    sys_rst_i <= 1'b1;
    repeat (12) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    #1;
    check("term pin default", 16'h0010, 16'(term_sel_o));
    check("gain pin default", 16'h000a, 16'(fine_gain_o));
    check("gain pct default", 16'h0004, 16'(fine_gain_pct_o));
    check("class pin default", 16'h0000, 16'(quality_class_o));
    check("read data default", 16'h0000, rdata_o);
    bus_rd(OFS_TERM, q);
    check("term word default", 16'h1000, q);
    bus_rd(OFS_GAIN, q);
    check("gain word default", 16'h000a, q);
    bus_rd(OFS_QUAL, q);
    check("quality word default", 16'h0000, q);
  endtask : reset_chk

  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    seed = 29;
    n_fail = 0;
    checked = 0;
    ref_clk_i = 1'b0;
    sys_rst_i = 1'b1;
    bus_req_i = '0;
    quality_i = '0;
    reset_chk();
    // every fine gain code, write then read with no gap, reserved bits random
    for (i = 0; i < 16; i++) begin
      d = 16'($random(seed));
      d[3:0] = i[3:0];
      bus_cycle(1'b1, OFS_GAIN, d);
      bus_cycle(1'b0, OFS_GAIN, 16'h0000);
      bus_idle_read(q);
      check("gain word", {12'h000, i[3:0]}, q);
      check("gain pin", 16'(i), 16'(fine_gain_o));
      check("gain pct", 16'((i - 8) * 2), 16'(fine_gain_pct_o));
    end
    // every termination code
    for (i = 0; i < 32; i++) begin
      d = 16'($random(seed));
      d[12:8] = i[4:0];
      bus_cycle(1'b1, OFS_TERM, d);
      bus_cycle(1'b0, OFS_TERM, 16'h0000);
      bus_idle_read(q);
      check("term word", {3'h0, i[4:0], 8'h00}, q);
      check("term pin", 16'(i), 16'(term_sel_o));
    end
    // unmapped place: reads zero, write leaves the settings alone
    bus_cycle(1'b1, 16'h0402, 16'hffff);
    bus_rd(16'h0402, q);
    check("unmapped word", 16'h0000, q);
    check("term kept", 16'h001f, 16'(term_sel_o));
    check("gain kept", 16'h000f, 16'(fine_gain_o));
    // quality samples: class boundaries, link down (values above 255), random
    qv = {0, 39, 40, 70, 71, 255, 1, 300, 999};
    repeat (8) qv.push_back($unsigned($random(seed)) % 256);
    foreach (qv[k]) begin
      lk = (qv[k] < 256) ? 1 : 0;
      v = (lk != 0) ? qv[k] : 0;
      @(posedge ref_clk_i);
      quality_i <= '{sample: 1'b1, link_up: lk[0], value: qv[k][7:0]};
      // inputs without the sample pulse must be ignored
      @(posedge ref_clk_i);
      quality_i <= '{sample: 1'b0, link_up: 1'($random(seed)), value: 8'($random(seed))};
      bus_cycle(1'b1, OFS_QUAL, 16'($random(seed)));
      bus_rd(OFS_QUAL, q);
      check("quality word", 16'((exp_class(lk, v) << 8) | v), q);
      check("class pin", 16'(exp_class(lk, v)), 16'(quality_class_o));
    end
    // quality writes left the settings alone; read data stands one cycle only
    check("term after quality writes", 16'h001f, 16'(term_sel_o));
    check("gain after quality writes", 16'h000f, 16'(fine_gain_o));
    @(posedge ref_clk_i);
    #1 check("read data after read", 16'h0000, rdata_o);
    // a reset in mid-run brings every default back
    reset_chk();
    test_done();
  end

  // watchdog: the run needs well under a thousand cycles
  initial begin
    #100000;
    n_fail++;
    test_done();
  end

endmodule : lqld_regs_tb

`default_nettype wire
